// File: hw/fpms_defines.svh
// Constants for the flash programming-mode and security block.
// Assumes it is included by bare name from the design and bench modules.
`ifndef FPMS_DEFINES_SVH
`define FPMS_DEFINES_SVH

// Special addresses seen by the programmer in programming mode.
`define FPMS_SEC_ADDR     16'hFFFF
`define FPMS_SEED0_ADDR   16'hFF7F
`define FPMS_SEED1_ADDR   16'hFF3F

// Erased value of every cell.
`define FPMS_ERASED_BYTE  8'hFF

// Security byte bit positions.
`define FPMS_LOCK_BIT     0
`define FPMS_RESTRICT_BIT 1
`define FPMS_ENC_BIT      2

// APB register byte offsets.
`define FPMS_REG_STATUS   12'h000
`define FPMS_REG_PROBE    12'h004
`define FPMS_REG_RESULT   12'h008

// Field positions inside the APB registers.
`define FPMS_ST_PM_BIT    3
`define FPMS_ST_ENC_BIT   4
`define FPMS_ST_BUSY_BIT  5
`define FPMS_ST_SEC_LSB   8
`define FPMS_PROBE_INT    16
`define FPMS_RES_INT      0
`define FPMS_RES_EXT      1

`endif

// File: hw/fpms_pkg.sv
// Types shared by the flash programming-mode and security block.
// Assumes it is compiled before every module that imports it.
package fpms_pkg;

  // Operation selected by the static control pin levels.
  typedef enum logic [2:0] {
    FPMS_OP_NONE,
    FPMS_OP_READ,
    FPMS_OP_ODIS,
    FPMS_OP_PROG,
    FPMS_OP_PVER,
    FPMS_OP_ERASE,
    FPMS_OP_EVER,
    FPMS_OP_INHIBIT
  } fpms_op_e;

  // Sequencer states.
  typedef enum logic [1:0] {
    FPMS_ST_IDLE,
    FPMS_ST_RMW_RD,
    FPMS_ST_RMW_WR,
    FPMS_ST_ERASE
  } fpms_state_e;

  // Static control pins driven by the external programmer.
  typedef struct packed {
    logic reset_pin;
    logic addr_latch_strobe;
    logic program_fetch_strobe_n;
    logic erase_select_ctl;
    logic mode_select_hi_a;
    logic mode_select_hi_b;
    logic output_mode_ctl;
    logic chip_select_n;
    logic output_enable_n;
    logic external_access_pin;
    logic program_level;
    logic erase_level;
  } fpms_ctl_s;

endpackage

// File: hw/fpms_mem.sv
// Code memory array with one write port and one registered read port.
// Assumes the caller sequences read-modify-write and the erase sweep.
`timescale 1ns/1ps

module fpms_mem #(
  parameter int AW = 16,
  parameter int DW = 8
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata_q
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // The array itself has no reset; only the read register does, so it maps to RAM.
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Read data come out of a register one cycle after the address.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= mem[raddr];
    end
  end

endmodule

// File: hw/fpms_top.sv
// Flash programming-mode interface with security byte, seeds and read-out scrambling.
// Assumes static programmer pins from outside the pclk domain and an APB master.
//
// Chosen here: the address map and the APB register port.
`timescale 1ns/1ps
`include "fpms_defines.svh"

module fpms_top
  import fpms_pkg::*;
#(
  parameter int ADDR_W      = 16,
  parameter int ERASE_WORDS = 65536
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire fpms_ctl_s   ctl_pins,
  input  wire logic [15:0] addr_pins,
  input  wire logic [7:0]  data_pins_in,
  output logic      [7:0]  data_pins_out,
  output logic             data_pins_oe
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************

  // Pin decode; anything outside the documented table selects nothing.
  function automatic fpms_op_e decode_op(input fpms_ctl_s c);
    fpms_op_e op;
    op = FPMS_OP_NONE;
    if (c.reset_pin && !c.addr_latch_strobe && c.program_fetch_strobe_n &&
        !c.mode_select_hi_a && !c.mode_select_hi_b && !c.output_mode_ctl) begin
      if (c.chip_select_n && c.output_enable_n) begin
        op = FPMS_OP_INHIBIT;
      end else if (c.erase_level && c.erase_select_ctl) begin
        op = !c.chip_select_n ? FPMS_OP_ERASE : FPMS_OP_EVER;
      end else if (c.program_level && !c.erase_select_ctl) begin
        op = !c.chip_select_n ? FPMS_OP_PROG : FPMS_OP_PVER;
      end else if (c.external_access_pin && !c.erase_select_ctl &&
                   !c.program_level && !c.erase_level && !c.chip_select_n) begin
        op = c.output_enable_n ? FPMS_OP_ODIS : FPMS_OP_READ;
      end
    end
    return op;
  endfunction

  // Address-keyed scrambling value, so repeated verify reads give the same byte.
  function automatic logic [7:0] scramble_key(input logic [15:0] a,
                                              input logic [7:0]  s0,
                                              input logic [7:0]  s1);
    logic [7:0] lo;
    logic [7:0] hi;
    lo = a[7:0] ^ s0;
    hi = {a[14:8], a[15]} ^ s1;
    return 8'(lo + {hi[6:0], hi[7]});
  endfunction

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************

  fpms_ctl_s   ctl_s1_q, ctl_s2_q;
  logic [15:0] addr_s1_q, addr_s2_q;
  logic [7:0]  din_s1_q, din_s2_q;

  // The programmer's pins are asynchronous to pclk, so each takes two flops.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_s1_q  <= '0;
      ctl_s2_q  <= '0;
      addr_s1_q <= '0;
      addr_s2_q <= '0;
      din_s1_q  <= '0;
      din_s2_q  <= '0;
    end else begin
      ctl_s1_q  <= ctl_pins;
      ctl_s2_q  <= ctl_s1_q;
      addr_s1_q <= addr_pins;
      addr_s2_q <= addr_s1_q;
      din_s1_q  <= data_pins_in;
      din_s2_q  <= din_s1_q;
    end
  end

  // ****************************************************************
  // Operation sequencer and security state
  // ****************************************************************

  fpms_op_e    op_q, op_d, op_prev_q;
  fpms_state_e st_q, st_d;
  logic [15:0] addr_q, lat_addr_q, lat_addr_d;
  logic [7:0]  lat_data_q, lat_data_d;
  logic [7:0]  sec_q, sec_d, seed0_q, seed0_d, seed1_q, seed1_d;
  logic [ADDR_W-1:0] cnt_q, cnt_d;
  logic [7:0]  dout_d;
  logic        doe_d;
  logic        mem_we;
  logic [ADDR_W-1:0] mem_waddr, mem_raddr;
  logic [7:0]  mem_wdata, mem_rdata;
  logic        enc_active, pm_active, code_addr, is_read;

  assign pm_active  = (op_q != FPMS_OP_NONE);
  assign enc_active = (seed0_q != `FPMS_ERASED_BYTE) ||
                      (seed1_q != `FPMS_ERASED_BYTE);
  assign code_addr  = (addr_q != `FPMS_SEC_ADDR) && (addr_q != `FPMS_SEED0_ADDR) &&
                      (addr_q != `FPMS_SEED1_ADDR);
  assign is_read    = (op_q == FPMS_OP_READ) || (op_q == FPMS_OP_PVER) ||
                      (op_q == FPMS_OP_EVER);

  // The security byte and seed cells are modelled as flops that power up erased; presetn stands for power-on.
  always_comb begin
    op_d       = decode_op(ctl_s2_q);
    st_d       = st_q;
    cnt_d      = cnt_q;
    sec_d      = sec_q;
    seed0_d    = seed0_q;
    seed1_d    = seed1_q;
    lat_addr_d = lat_addr_q;
    lat_data_d = lat_data_q;
    mem_we     = 1'b0;
    mem_waddr  = lat_addr_q[ADDR_W-1:0];
    mem_wdata  = `FPMS_ERASED_BYTE;
    mem_raddr  = addr_q[ADDR_W-1:0];
    dout_d     = `FPMS_ERASED_BYTE;
    doe_d      = 1'b0;
    case (st_q)
      FPMS_ST_IDLE: begin
        // Acting only on entry to erase or program keeps a held level from repeating it.
        if (op_q == FPMS_OP_ERASE && op_prev_q != FPMS_OP_ERASE) begin
          st_d    = FPMS_ST_ERASE;
          cnt_d   = '0;
          sec_d   = `FPMS_ERASED_BYTE;
          seed0_d = `FPMS_ERASED_BYTE;
          seed1_d = `FPMS_ERASED_BYTE;
        end else if (op_q == FPMS_OP_PROG && op_prev_q != FPMS_OP_PROG) begin
          lat_addr_d = addr_q;
          lat_data_d = din_s2_q;
          if (addr_q == `FPMS_SEC_ADDR) begin
            sec_d = sec_q & din_s2_q;
          end else if (addr_q == `FPMS_SEED0_ADDR) begin
            if (sec_q[`FPMS_ENC_BIT]) begin
              seed0_d = seed0_q & din_s2_q;
            end
          end else if (addr_q == `FPMS_SEED1_ADDR) begin
            if (sec_q[`FPMS_ENC_BIT]) begin
              seed1_d = seed1_q & din_s2_q;
            end
          end else if (sec_q[`FPMS_LOCK_BIT]) begin
            st_d = FPMS_ST_RMW_RD;
          end
        end else if (is_read) begin
          doe_d = 1'b1;
          if (addr_q == `FPMS_SEC_ADDR) begin
            dout_d = sec_q;
          end else if (!code_addr) begin
            if (sec_q[`FPMS_ENC_BIT]) begin
              dout_d = (addr_q == `FPMS_SEED0_ADDR) ? seed0_q : seed1_q;
            end
          end else if (sec_q[`FPMS_LOCK_BIT]) begin
            dout_d = enc_active ?
                     8'(mem_rdata + scramble_key(addr_q, seed0_q, seed1_q)) :
                     mem_rdata;
          end
        end
      end
      FPMS_ST_RMW_RD: begin
        mem_raddr = lat_addr_q[ADDR_W-1:0];
        st_d      = FPMS_ST_RMW_WR;
      end
      FPMS_ST_RMW_WR: begin
        // Programming can only pull bits low, so the old byte is ANDed in.
        mem_we    = 1'b1;
        mem_wdata = mem_rdata & lat_data_q;
        st_d      = FPMS_ST_IDLE;
      end
      FPMS_ST_ERASE: begin
        // The sweep is one operation to the programmer; it takes one pclk per byte.
        mem_we    = 1'b1;
        mem_waddr = cnt_q;
        mem_wdata = `FPMS_ERASED_BYTE;
        cnt_d     = ADDR_W'(cnt_q + 1'b1);
        if (cnt_q == ADDR_W'(ERASE_WORDS - 1)) begin
          st_d = FPMS_ST_IDLE;
        end
      end
      default: st_d = FPMS_ST_IDLE;
    endcase
  end

  // Sequencer and security registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_q          <= FPMS_OP_NONE;
      op_prev_q     <= FPMS_OP_NONE;
      addr_q        <= '0;
      st_q          <= FPMS_ST_IDLE;
      cnt_q         <= '0;
      sec_q         <= `FPMS_ERASED_BYTE;
      seed0_q       <= `FPMS_ERASED_BYTE;
      seed1_q       <= `FPMS_ERASED_BYTE;
      lat_addr_q    <= '0;
      lat_data_q    <= '0;
      data_pins_out <= `FPMS_ERASED_BYTE;
      data_pins_oe  <= 1'b0;
    end else begin
      op_q          <= op_d;
      op_prev_q     <= op_q;
      addr_q        <= addr_s2_q;
      st_q          <= st_d;
      cnt_q         <= cnt_d;
      sec_q         <= sec_d;
      seed0_q       <= seed0_d;
      seed1_q       <= seed1_d;
      lat_addr_q    <= lat_addr_d;
      lat_data_q    <= lat_data_d;
      data_pins_out <= dout_d;
      data_pins_oe  <= doe_d;
    end
  end

  fpms_mem #(
    .AW (ADDR_W),
    .DW (8)
  ) u_mem (
    .clk     (pclk),
    .rst_n   (presetn),
    .we      (mem_we),
    .waddr   (mem_waddr),
    .wdata   (mem_wdata),
    .raddr   (mem_raddr),
    .rdata_q (mem_rdata)
  );

  // ****************************************************************
  // APB slave: status, code-read probe and its result
  // ****************************************************************

  logic [16:0] probe_q, probe_d;
  logic [1:0]  res_q, res_d;
  logic [31:0] prdata_d;
  logic        pready_d, pslverr_d;
  logic        acc;

  assign acc = psel && penable && !pready;

  // One wait state: pready rises in the second access cycle, then drops.
  always_comb begin
    probe_d   = probe_q;
    prdata_d  = prdata;
    pready_d  = acc;
    pslverr_d = 1'b0;
    // Internal route unless fetching from outside with the restrict bit cleared.
    res_d[`FPMS_RES_INT] = probe_q[`FPMS_PROBE_INT] ||
                           sec_q[`FPMS_RESTRICT_BIT];
    res_d[`FPMS_RES_EXT] = 1'b1;
    if (acc) begin
      prdata_d = '0;
      if (paddr == `FPMS_REG_STATUS) begin
        prdata_d[2:0]               = op_q;
        prdata_d[`FPMS_ST_PM_BIT]   = pm_active;
        prdata_d[`FPMS_ST_ENC_BIT]  = enc_active;
        prdata_d[`FPMS_ST_BUSY_BIT] = (st_q != FPMS_ST_IDLE);
        if (pm_active) begin
          prdata_d[`FPMS_ST_SEC_LSB +: 8] = sec_q;
        end
      end else if (paddr == `FPMS_REG_PROBE) begin
        if (pwrite) begin
          probe_d = pwdata[16:0];
        end else begin
          prdata_d[16:0] = probe_q;
        end
      end else if (paddr == `FPMS_REG_RESULT) begin
        prdata_d[1:0] = res_q;
      end else begin
        pslverr_d = 1'b1;
      end
    end
  end

  // Bus registers; every bus output comes straight from a flop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      probe_q <= '0;
      res_q   <= '0;
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      probe_q <= probe_d;
      res_q   <= res_d;
      prdata  <= prdata_d;
      pready  <= pready_d;
      pslverr <= pslverr_d;
    end
  end

  // ****************************************************************
  // Assertions and covers
  // ****************************************************************

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_inhibit_no_change: assert property (
    (st_q == FPMS_ST_IDLE && op_q == FPMS_OP_INHIBIT) |=>
      (st_q == FPMS_ST_IDLE) && $stable(sec_q) && $stable(seed0_q))
    else $error("inhibit condition changed stored state");

  a_erase_clears_all: assert property (
    (st_q == FPMS_ST_IDLE && op_q == FPMS_OP_ERASE && op_prev_q != FPMS_OP_ERASE) |=>
      (st_q == FPMS_ST_ERASE) && (sec_q == `FPMS_ERASED_BYTE) &&
      (seed0_q == `FPMS_ERASED_BYTE) && (seed1_q == `FPMS_ERASED_BYTE))
    else $error("erase did not clear security byte and seeds");

  a_sec_rise_erase: assert property (
    ((sec_q & ~$past(sec_q)) != 8'h00) |-> ($past(st_d) == FPMS_ST_ERASE))
    else $error("security bit returned to one without erase");

  a_lock_hides_code: assert property (
    (st_q == FPMS_ST_IDLE && is_read && code_addr && !sec_q[`FPMS_LOCK_BIT]) |=>
      (data_pins_out == `FPMS_ERASED_BYTE) && data_pins_oe)
    else $error("code byte visible while locked");

  a_seed_denied: assert property (
    (st_q == FPMS_ST_IDLE && op_q == FPMS_OP_PROG && op_prev_q != FPMS_OP_PROG &&
     !sec_q[`FPMS_ENC_BIT]) |=> $stable(seed0_q) && $stable(seed1_q))
    else $error("seed changed while access denied");

  a_scramble_out: assert property (
    (st_q == FPMS_ST_IDLE && is_read && code_addr && sec_q[`FPMS_LOCK_BIT] &&
     enc_active) |=>
      data_pins_out == 8'($past(mem_rdata) +
                          scramble_key($past(addr_q), $past(seed0_q), $past(seed1_q))))
    else $error("read-out byte not scrambled");

  a_sec_hidden: assert property (
    (acc && !pwrite && paddr == `FPMS_REG_STATUS && !pm_active) |=>
      prdata[`FPMS_ST_SEC_LSB +: 8] == 8'h00)
    else $error("security byte visible outside programming mode");

  a_probe_route: assert property (
    (!probe_q[`FPMS_PROBE_INT] && !sec_q[`FPMS_RESTRICT_BIT]) |=> !res_q[`FPMS_RES_INT])
    else $error("restricted code read reached internal code");

  a_odis_float: assert property (
    (op_q == FPMS_OP_ODIS) |=> !data_pins_oe)
    else $error("data port driven during output disable");

  c_erase: cover property (st_q == FPMS_ST_ERASE ##1 st_q == FPMS_ST_IDLE);
  c_program: cover property (st_q == FPMS_ST_RMW_WR);
  c_enc_read: cover property (enc_active && data_pins_oe);

endmodule

// File: test/fpms_prog_model.sv
// Behavioural parallel programmer that sets static control pins, address and data.
// Assumes the bench calls apply() from one process and samples the device itself.
`timescale 1ns/1ps

module fpms_prog_model
  import fpms_pkg::*;
(
  input  wire logic  pclk,
  output fpms_ctl_s  ctl,
  output logic [15:0] addr,
  output logic [7:0]  dout
);
  logic       drv_q;
  logic [7:0] dat_q;
  logic [7:0] pat_q;

  // Pins idle with the part out of programming mode until the first operation.
  initial begin
    ctl = '0;
    ctl.program_fetch_strobe_n = 1'b1;
    addr = 16'h0000;
    dat_q = 8'h00;
    drv_q = 1'b0;
    pat_q = 8'h5a;
  end

  // A released data bus shows a changing pattern, so stale data can never pass.
  always @(posedge pclk) begin
    pat_q <= {pat_q[6:0], ~pat_q[7]};
  end
  assign dout = drv_q ? dat_q : pat_q;

  // Sets one operation by static levels and holds it for the given number of cycles.
  task automatic apply(input fpms_op_e op, input logic [15:0] a, input logic [7:0] d,
                       input int hold);
    fpms_ctl_s c;
    @(posedge pclk);
    c = '0;
    c.reset_pin = 1'b1;
    c.program_fetch_strobe_n = 1'b1;
    c.external_access_pin = 1'b1;
    case (op)
      FPMS_OP_READ: c.output_enable_n = 1'b0;
      FPMS_OP_ODIS: c.output_enable_n = 1'b1;
      FPMS_OP_PROG: begin
        c.output_enable_n = 1'b1;
        c.program_level = 1'b1;
      end
      FPMS_OP_PVER: begin
        c.chip_select_n = 1'b1;
        c.program_level = 1'b1;
      end
      FPMS_OP_ERASE: begin
        c.erase_select_ctl = 1'b1;
        c.output_enable_n = 1'b1;
        c.erase_level = 1'b1;
      end
      FPMS_OP_EVER: begin
        c.erase_select_ctl = 1'b1;
        c.chip_select_n = 1'b1;
        c.erase_level = 1'b1;
      end
      default: begin
        c.chip_select_n = 1'b1;
        c.output_enable_n = 1'b1;
        c.program_level = 1'b1;
      end
    endcase
    ctl <= c;
    addr <= a;
    dat_q <= d;
    drv_q <= (op == FPMS_OP_PROG) || (op == FPMS_OP_ERASE) || (op == FPMS_OP_INHIBIT);
    repeat (hold) @(posedge pclk);
  endtask
endmodule

// File: test/fpms_top_tb.sv
// Self-checking bench for the programming-mode block: pins through the model, APB here.
// Assumes a shortened array (ADDR_W=4, ERASE_WORDS=16) and one-wait-state APB answers.
`timescale 1ns/1ps
`include "fpms_defines.svh"

`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin failures++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end

module fpms_top_tb
  import fpms_pkg::*;
;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, pready, pslverr, data_pins_oe;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  data_pins_in, data_pins_out, d, s0, e;
  logic [7:0]  mem [16];
  logic [15:0] addr_pins;
  fpms_ctl_s   ctl_pins;
  logic        er;
  int          failures = 0;
  int          checks = 0;
  int          seed = 32'hc323;

  always #12.5 pclk = ~pclk;

  fpms_top #(.ADDR_W(4), .ERASE_WORDS(16)) fpms_top_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ctl_pins(ctl_pins), .addr_pins(addr_pins), .data_pins_in(data_pins_in),
    .data_pins_out(data_pins_out), .data_pins_oe(data_pins_oe));

  fpms_prog_model fpms_prog_model_inst (
    .pclk(pclk), .ctl(ctl_pins), .addr(addr_pins), .dout(data_pins_in));

  // Scramble value chosen by the design: depends only on address and seeds.
  function automatic logic [7:0] scr(input logic [15:0] a, input logic [7:0] k0, k1);
    logic [7:0] t;
    t = {a[14:8], a[15]} ^ k1;
    return (a[7:0] ^ k0) + {t[6:0], t[7]};
  endfunction

  task automatic give_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // One APB transfer; the request stands until pready is seen at a rising edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Only a wait that ended without pready is a timeout, not one that hit the bound.
    if (pready !== 1'b1) begin
      failures++;
      give_verdict();
    end
  endtask

  task automatic prog(input logic [15:0] a, input logic [7:0] v);
    fpms_prog_model_inst.apply(FPMS_OP_PROG, a, v, 10);
    fpms_prog_model_inst.apply(FPMS_OP_ODIS, a, 8'h00, 4);
  endtask

  task automatic rdchk(input fpms_op_e op, input logic [15:0] a, input logic [7:0] ex);
    fpms_prog_model_inst.apply(op, a, 8'h00, 10);
    `CHK("oe", 1'b1, data_pins_oe)
    `CHK("data", ex, data_pins_out)
  endtask

  // Erase is awaited through the busy flag, bounded, then the condition is left.
  task automatic erase_all();
    int n;
    fpms_prog_model_inst.apply(FPMS_OP_ERASE, 16'h0000, 8'hFF, 6);
    n = 0;
    do begin apb(1'b0, `FPMS_REG_STATUS, 32'h0); n++; end
    while (rd[`FPMS_ST_BUSY_BIT] !== 1'b0 && n < 40);
    if (rd[`FPMS_ST_BUSY_BIT] !== 1'b0) begin
      failures++;
      give_verdict();
    end
    fpms_prog_model_inst.apply(FPMS_OP_ODIS, 16'h0000, 8'h00, 6);
  endtask

  task automatic status(input logic [7:0] sec, input logic enc);
    apb(1'b0, `FPMS_REG_STATUS, 32'h0);
    `CHK("sec", sec, rd[15:8])
    `CHK("enc", enc, rd[`FPMS_ST_ENC_BIT])
    `CHK("op", FPMS_OP_ODIS, rd[2:0])
    `CHK("pm", 1'b1, rd[`FPMS_ST_PM_BIT])
  endtask

  // Watchdog that turns a hang into a counted failure.
  initial begin
    repeat (60000) @(posedge pclk);
    failures++;
    give_verdict();
  end

  // Main sequence: random data with corner cases on the security byte and seeds.
  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    `CHK("oe_rst", 1'b0, data_pins_oe)
    apb(1'b0, `FPMS_REG_STATUS, 32'h0);
    `CHK("sec_hidden", 8'h00, rd[15:8])
    `CHK("op_none", FPMS_OP_NONE, rd[2:0])
    `CHK("pm_off", 1'b0, rd[`FPMS_ST_PM_BIT])
    apb(1'b0, 12'h0FC, 32'h0);
    `CHK("unmapped", 1'b1, er)
    fpms_prog_model_inst.apply(FPMS_OP_ODIS, 16'h0000, 8'h00, 6);
    `CHK("oe_odis", 1'b0, data_pins_oe)
    rdchk(FPMS_OP_READ, `FPMS_SEC_ADDR, 8'hFF);
    erase_all();
    for (int i = 0; i < 16; i++) rdchk(FPMS_OP_EVER, 16'(i), 8'hFF);
    for (int i = 0; i < 16; i++) begin
      mem[i] = 8'($random(seed));
      prog(16'(i), mem[i]);
      rdchk(FPMS_OP_PVER, 16'(i), mem[i]);
    end
    d = 8'($random(seed)) & 8'hFE;
    prog(16'h0003, d);
    mem[3] = mem[3] & d;
    rdchk(FPMS_OP_PVER, 16'h0003, mem[3]);
    fpms_prog_model_inst.apply(FPMS_OP_INHIBIT, 16'h0005, 8'h00, 10);
    `CHK("oe_inh", 1'b0, data_pins_oe)
    rdchk(FPMS_OP_READ, 16'h0005, mem[5]);
    apb(1'b1, `FPMS_REG_PROBE, 32'h0000_0002);
    apb(1'b0, `FPMS_REG_RESULT, 32'h0);
    `CHK("restrict_off", 2'b11, rd[1:0])
    prog(`FPMS_SEC_ADDR, 8'hFD);
    apb(1'b0, `FPMS_REG_RESULT, 32'h0);
    `CHK("restrict_ext", 2'b10, rd[1:0])
    apb(1'b1, `FPMS_REG_PROBE, 32'h0001_0002);
    apb(1'b0, `FPMS_REG_RESULT, 32'h0);
    `CHK("restrict_int", 2'b11, rd[1:0])
    prog(`FPMS_SEC_ADDR, 8'hFF);
    status(8'hFD, 1'b0);
    prog(`FPMS_SEC_ADDR, 8'hF9);
    prog(`FPMS_SEED0_ADDR, 8'h00);
    status(8'hF9, 1'b0);
    prog(`FPMS_SEC_ADDR, 8'hF8);
    prog(16'h0003, 8'h00);
    rdchk(FPMS_OP_READ, 16'h0003, 8'hFF);
    erase_all();
    status(8'hFF, 1'b0);
    rdchk(FPMS_OP_EVER, 16'h0003, 8'hFF);
    s0 = 8'($random(seed)) & 8'hF7;
    prog(`FPMS_SEED0_ADDR, s0);
    status(8'hFF, 1'b1);
    for (int i = 0; i < 4; i++) begin
      prog(16'(i), mem[i]);
      e = mem[i] + scr(16'(i), s0, 8'hFF);
      rdchk(FPMS_OP_PVER, 16'(i), e);
    end
    // A plain read is scrambled the same way as a verify read.
    rdchk(FPMS_OP_READ, 16'h0002, 8'(mem[2] + scr(16'h0002, s0, 8'hFF)));
    rdchk(FPMS_OP_READ, `FPMS_SEED0_ADDR, s0);
    prog(`FPMS_SEED0_ADDR, 8'hFF);
    status(8'hFF, 1'b1);
    erase_all();
    status(8'hFF, 1'b0);
    rdchk(FPMS_OP_READ, `FPMS_SEED0_ADDR, 8'hFF);
    give_verdict();
  end
endmodule
